// >>> verilog/aim_pkg.sv
// Purpose: constants for the adc input mix configuration block
// Assumes: registers reached by 7-bit address, 8-bit data
// Notes: register map and field positions below
package aim_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam logic [ADDR_W-1:0] OFS_MIC3_MIX = 7'h12;
	localparam logic [ADDR_W-1:0] OFS_LINE1_MIX = 7'h13;
	localparam logic [7:0] RST_MIC3_MIX = 8'hff;
	localparam logic [7:0] RST_LINE1_MIX = 8'h78;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int LMIC_LSB = 4;
	localparam int RMIC_LSB = 0;
	localparam int LINE_DIFF_BIT = 7;
	localparam int LINE_LVL_LSB = 3;
	localparam int PWR_BIT = 2;
	localparam int STEP_LSB = 0;
	localparam logic [3:0] LVL_OFF = 4'hf;
	localparam int GAIN_W = 7;
	localparam logic [GAIN_W-1:0] GAIN_RST = 7'h00;
	typedef enum logic [1:0] {
		AIM_STEP_EVERY = 2'b00,
		AIM_STEP_SECOND = 2'b01,
		AIM_STEP_OFF_A = 2'b10,
		AIM_STEP_OFF_B = 2'b11
	} aim_step_e;
endpackage

// >>> verilog/aim_step_if.sv
// Purpose: carries stepping setup to the gain stepper and its result back
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
interface aim_step_if;
	import aim_pkg::*;
	logic [1:0] rate;
	logic tick;
	logic [GAIN_W-1:0] target;
	logic [GAIN_W-1:0] gain;
	modport ctrl (output rate, output tick, output target, input gain);
	modport stepper (input rate, input tick, input target, output gain);
endinterface

// >>> verilog/aim_gain_stepper.sv
// Purpose: walks the applied left gain toward its target
// Assumes: tick is a one-cycle sample-rate strobe on the core clock
// Notes: one gain code per step, in either direction
`timescale 1ns/1ps
module aim_gain_stepper (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// setup and result
	aim_step_if.stepper s
);
	import aim_pkg::*;

	logic [GAIN_W-1:0] gain_r, gain_nxt;
	logic skip_r, skip_nxt;

	// ---------------------------------------------------------------
	// next gain
	// ---------------------------------------------------------------
	always_comb begin
		gain_nxt = gain_r;
		skip_nxt = skip_r;
		unique case (aim_step_e'(s.rate))
			AIM_STEP_EVERY: begin
				skip_nxt = 1'b0;
				if (s.tick && gain_r != s.target) begin
					gain_nxt = (gain_r < s.target) ? gain_r + 7'h01
						: gain_r - 7'h01;
				end
			end
			AIM_STEP_SECOND: begin
				if (s.tick) begin
					skip_nxt = ~skip_r;
					if (!skip_r && gain_r != s.target) begin
						gain_nxt = (gain_r < s.target) ? gain_r + 7'h01
							: gain_r - 7'h01;
					end
				end
			end
			AIM_STEP_OFF_A, AIM_STEP_OFF_B: begin
				skip_nxt = 1'b0;
				gain_nxt = s.target;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			gain_r <= GAIN_RST;
			skip_r <= 1'b0;
		end else begin
			gain_r <= gain_nxt;
			skip_r <= skip_nxt;
		end
	end

	assign s.gain = gain_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence stepping_on;
		!s.rate[1];
	endsequence
	sequence no_tick;
		!s.tick;
	endsequence
	sequence half_tick;
		s.rate == 2'b01 && s.tick;
	endsequence

	a_step_size_one: assert property (stepping_on |=>
		(gain_r == $past(gain_r) + 7'h01) || (gain_r == $past(gain_r) - 7'h01)
		|| (gain_r == $past(gain_r)))
		else $error("gain moved more than one step");
	a_step_needs_tick: assert property (stepping_on and no_tick |=>
		$stable(gain_r))
		else $error("gain moved without a sample tick");
	a_step_off_jumps: assert property (s.rate[1] |=>
		gain_r == $past(s.target))
		else $error("disabled stepping did not apply at once");
	// a tick that stepped is followed by a tick that must skip
	a_step_half_rate: assert property (half_tick ##1
		(s.rate == 2'b01 && !s.tick && gain_r != $past(gain_r))
		##1 half_tick |=> $stable(gain_r))
		else $error("half rate stepped on two ticks in a row");
endmodule

// >>> verilog/aim_mix_config.sv
// Purpose: record-path mix and left adc setup registers
// Assumes: access port and sample tick come from core-clock logic
// Notes: reserved level codes are stored as written
`timescale 1ns/1ps
module aim_mix_config (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// register access port
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [aim_pkg::ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	// left gain setup from the gain register, sample strobe
	input wire logic [aim_pkg::GAIN_W-1:0] i_left_gain_target,
	input wire logic i_sample_tick,
	// settings to the analog mixers
	output logic [3:0] o_third_mic_left_input_level,
	output logic o_third_mic_left_input_connect,
	output logic [3:0] o_third_mic_right_input_level,
	output logic o_third_mic_right_input_connect,
	output logic o_first_line_left_input_diff,
	output logic [3:0] o_first_line_left_input_level,
	output logic o_first_line_left_input_connect,
	output logic o_left_adc_power_up,
	output logic [aim_pkg::GAIN_W-1:0] o_left_gain_applied
);
	import aim_pkg::*;

	logic [7:0] mic3_mix_r, mic3_mix_nxt;
	logic [7:0] line1_mix_r, line1_mix_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic lmic_con_r, rmic_con_r, line1_con_r;
	logic lmic_con_nxt, rmic_con_nxt, line1_con_nxt;

	aim_step_if step ();

	// ---------------------------------------------------------------
	// register writes and read port
	// ---------------------------------------------------------------
	// host owns reserved codes; storing them unchanged keeps readback honest
	always_comb begin
		mic3_mix_nxt = mic3_mix_r;
		line1_mix_nxt = line1_mix_r;
		if (i_wr_en && i_addr == OFS_MIC3_MIX) begin
			mic3_mix_nxt = i_wr_data;
		end
		if (i_wr_en && i_addr == OFS_LINE1_MIX) begin
			line1_mix_nxt = i_wr_data;
		end
		rd_data_nxt = rd_data_r;
		if (i_rd_en) begin
			unique case (i_addr)
				OFS_MIC3_MIX: rd_data_nxt = mic3_mix_r;
				OFS_LINE1_MIX: rd_data_nxt = line1_mix_r;
				default: rd_data_nxt = RD_UNMAPPED;
			endcase
		end
		lmic_con_nxt = mic3_mix_nxt[LMIC_LSB+:4] != LVL_OFF;
		rmic_con_nxt = mic3_mix_nxt[RMIC_LSB+:4] != LVL_OFF;
		line1_con_nxt = line1_mix_nxt[LINE_LVL_LSB+:4] != LVL_OFF;
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			mic3_mix_r <= RST_MIC3_MIX;
			line1_mix_r <= RST_LINE1_MIX;
			rd_data_r <= RD_UNMAPPED;
			lmic_con_r <= 1'b0;
			rmic_con_r <= 1'b0;
			line1_con_r <= 1'b0;
		end else begin
			mic3_mix_r <= mic3_mix_nxt;
			line1_mix_r <= line1_mix_nxt;
			rd_data_r <= rd_data_nxt;
			lmic_con_r <= lmic_con_nxt;
			rmic_con_r <= rmic_con_nxt;
			line1_con_r <= line1_con_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_rd_data = rd_data_r;
	assign o_third_mic_left_input_level = mic3_mix_r[LMIC_LSB+:4];
	assign o_third_mic_right_input_level = mic3_mix_r[RMIC_LSB+:4];
	assign o_third_mic_left_input_connect = lmic_con_r;
	assign o_third_mic_right_input_connect = rmic_con_r;
	assign o_first_line_left_input_diff = line1_mix_r[LINE_DIFF_BIT];
	assign o_first_line_left_input_level = line1_mix_r[LINE_LVL_LSB+:4];
	assign o_first_line_left_input_connect = line1_con_r;
	assign o_left_adc_power_up = line1_mix_r[PWR_BIT];

	// ---------------------------------------------------------------
	// left gain stepping
	// ---------------------------------------------------------------
	assign step.rate = line1_mix_r[STEP_LSB+:2];
	assign step.tick = i_sample_tick;
	assign step.target = i_left_gain_target;
	assign o_left_gain_applied = step.gain;

	aim_gain_stepper u_stepper (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.s(step.stepper)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence mix_write;
		i_wr_en && i_addr == OFS_MIC3_MIX;
	endsequence
	sequence line_write;
		i_wr_en && i_addr == OFS_LINE1_MIX;
	endsequence
	sequence mix_read;
		i_rd_en && i_addr == OFS_MIC3_MIX;
	endsequence
	sequence line_read;
		i_rd_en && i_addr == OFS_LINE1_MIX;
	endsequence
	sequence other_read;
		i_rd_en && i_addr != OFS_MIC3_MIX && i_addr != OFS_LINE1_MIX;
	endsequence

	a_mic3_left_level: assert property (mix_write |=>
		o_third_mic_left_input_level == $past(i_wr_data[7:4]))
		else $error("left mic level not taken from bits 7..4");
	a_mic3_right_level: assert property (mix_write |=>
		o_third_mic_right_input_level == $past(i_wr_data[3:0]))
		else $error("right mic level not taken from bits 3..0");
	a_mic3_left_conn: assert property (o_third_mic_left_input_connect
		== (o_third_mic_left_input_level != 4'hf))
		else $error("left mic connect disagrees with level");
	a_mic3_right_conn: assert property (o_third_mic_right_input_connect
		== (o_third_mic_right_input_level != 4'hf))
		else $error("right mic connect disagrees with level");
	a_line_mode_bit: assert property (line_write |=>
		o_first_line_left_input_diff == $past(i_wr_data[7]))
		else $error("line mode not taken from bit 7");
	a_line_level_conn: assert property (line_write |=>
		o_first_line_left_input_level == $past(i_wr_data[6:3])
		&& o_first_line_left_input_connect == ($past(i_wr_data[6:3]) != 4'hf))
		else $error("line level or connect wrong after write");
	a_power_bit: assert property (line_write |=>
		o_left_adc_power_up == $past(i_wr_data[2]))
		else $error("power not taken from bit 2");
	// host leaves one idle cycle between a write and its readback
	a_readback_last: assert property (mix_write ##1 !i_wr_en ##1
		(i_rd_en && i_addr == OFS_MIC3_MIX && !i_wr_en) |=>
		o_rd_data == $past(i_wr_data, 3))
		else $error("readback differs from last write");
	a_settings_hold: assert property (!i_wr_en |=>
		$stable(mic3_mix_r) && $stable(line1_mix_r))
		else $error("setting changed without a write");
	a_mix_left_conn: assert property (mix_write |=>
		o_third_mic_left_input_connect == ($past(i_wr_data[7:4]) != 4'hf))
		else $error("left mic connect wrong after write");
	a_mix_right_conn: assert property (mix_write |=>
		o_third_mic_right_input_connect == ($past(i_wr_data[3:0]) != 4'hf))
		else $error("right mic connect wrong after write");
	a_line_conn_level: assert property (o_first_line_left_input_connect
		== (o_first_line_left_input_level != 4'hf))
		else $error("line connect disagrees with level");
	a_line_rate_bits: assert property (line_write |=>
		step.rate == $past(i_wr_data[1:0]))
		else $error("stepping rate not taken from bits 1..0");
	a_line_keeps_mix: assert property (line_write |=>
		$stable(mic3_mix_r))
		else $error("line write disturbed the mic register");
	a_mix_keeps_line: assert property (mix_write |=>
		$stable(line1_mix_r))
		else $error("mic write disturbed the line register");

	// ---------------------------------------------------------------
	// read port checks
	// ---------------------------------------------------------------
	// a read in the cycle of a write returns the old contents
	a_rd_mic_value: assert property (mix_read |=>
		o_rd_data == $past(mic3_mix_r))
		else $error("mic register read gave wrong data");
	a_rd_line_value: assert property (line_read |=>
		o_rd_data == $past(line1_mix_r))
		else $error("line register read gave wrong data");
	a_rd_unmapped: assert property (other_read |=>
		o_rd_data == RD_UNMAPPED)
		else $error("unmapped read did not give zero");
	a_rd_data_hold: assert property (!i_rd_en |=>
		$stable(o_rd_data))
		else $error("read data changed without a read");
endmodule

// >>> bench/aim_host.sv
// Purpose: host model driving the register port
// Assumes: each access starts 1ns after a rising edge
// Notes: level codes pass through legal() before any write
`timescale 1ns/1ps
module aim_host (
	// clock
	input wire logic i_core_clk,
	// register port
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [6:0] o_addr,
	output logic [7:0] o_wr_data,
	input wire logic [7:0] i_rd_data
);
	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 7'h00;
		o_wr_data = 8'h00;
	end
	// reserved codes folded to the off code
	function automatic logic [3:0] legal(input int r);
		int k;
		k = (r & 32'h7fff) % 10;
		legal = (k == 9) ? 4'hf : 4'(k);
	endfunction
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge i_core_clk) #1;
		o_wr_en = 1'b1;
		o_addr = a;
		o_wr_data = v;
		@(posedge i_core_clk) #1;
		o_wr_en = 1'b0;
		// stale data must not look valid
		o_wr_data = ~v;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge i_core_clk) #1;
		o_rd_en = 1'b1;
		o_addr = a;
		@(posedge i_core_clk) #1;
		o_rd_en = 1'b0;
		v = i_rd_data;
	endtask
endmodule

// >>> bench/aim_mix_config_tb.sv
// Purpose: self-checking bench for the mix configuration registers
// Assumes: host model owns the register port
// Notes: model keeps register copies and the gain walk
`timescale 1ns/1ps
module aim_mix_config_tb;
	import aim_pkg::*;
	// ---------------------------------------------------------------
	// wiring and model state
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tick = 1'b0;
	logic [GAIN_W-1:0] tgt = 7'h00;
	logic wr, rd, mlc, mrc, dif, llc, pw;
	logic [6:0] addr;
	logic [7:0] wd, rdat, d, r12, r13;
	logic [3:0] ml, mr, ll;
	logic [GAIN_W-1:0] g;
	int gm, ph, cyc, seed, n_checks, n_mismatch;
	always #2 clk = ~clk;
	aim_host host (.i_core_clk(clk), .o_wr_en(wr), .o_rd_en(rd),
		.o_addr(addr), .o_wr_data(wd), .i_rd_data(rdat));
	aim_mix_config uut (.i_core_clk(clk), .i_reset(rst), .i_wr_en(wr),
		.i_rd_en(rd), .i_addr(addr), .i_wr_data(wd), .o_rd_data(rdat),
		.i_left_gain_target(tgt), .i_sample_tick(tick),
		.o_third_mic_left_input_level(ml),
		.o_third_mic_left_input_connect(mlc),
		.o_third_mic_right_input_level(mr),
		.o_third_mic_right_input_connect(mrc),
		.o_first_line_left_input_diff(dif),
		.o_first_line_left_input_level(ll),
		.o_first_line_left_input_connect(llc),
		.o_left_adc_power_up(pw), .o_left_gain_applied(g));
	task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, d);
		cmp(17'(d), 17'(e));
	endtask
	task automatic chk_mix;
		cmp({ml, mr, dif, ll, pw, mlc, mrc, llc}, {r12, r13[7:2],
			r12[7:4] != 4'hf, r12[3:0] != 4'hf, r13[6:3] != 4'hf});
	endtask
	task automatic chk_gain;
		cmp(17'(g), 17'(gm));
	endtask
	task automatic setr(input logic [6:0] a, input logic [7:0] v);
		host.wr(a, v);
		if (a == OFS_MIC3_MIX) r12 = v;
		if (a == OFS_LINE1_MIX) r13 = v;
		if (a == OFS_LINE1_MIX && v[1:0] != AIM_STEP_SECOND) ph = 0;
	endtask
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk) #1;
			tick = 1'b1;
			if (r13[1]) gm = tgt;
			else if (!r13[0] || ph == 0)
				gm += (tgt > gm) ? 1 : ((gm > tgt) ? -1 : 0);
			if (r13[1:0] == AIM_STEP_SECOND) ph = !ph;
			@(posedge clk) #1;
			tick = 1'b0;
			chk_gain();
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		seed = 32'h2dcf;
		r12 = RST_MIC3_MIX;
		r13 = RST_LINE1_MIX;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		chk_mix();
		chk_gain();
		chk_rd(OFS_MIC3_MIX, RST_MIC3_MIX);
		chk_rd(OFS_LINE1_MIX, RST_LINE1_MIX);
		$display("test reset done");
		repeat (24) begin
			// one routing only, so one mode per write
			if ($random(seed) & 1) setr(OFS_MIC3_MIX,
				{host.legal($random(seed)), host.legal($random(seed))});
			else setr(OFS_LINE1_MIX, {1'($random(seed)),
				host.legal($random(seed)), 3'($random(seed))});
			chk_mix();
			chk_rd(OFS_MIC3_MIX, r12);
			chk_rd(OFS_LINE1_MIX, r13);
		end
		host.wr(7'h14, 8'h5a);
		chk_mix();
		chk_rd(7'h14, RD_UNMAPPED);
		$display("test fields done");
		tgt = 7'($random(seed));
		setr(OFS_LINE1_MIX, {r13[7:2], AIM_STEP_OFF_A});
		tk(1);
		setr(OFS_LINE1_MIX, {r13[7:2], AIM_STEP_EVERY});
		tgt = 7'(gm + 5);
		tk(6);
		repeat (5) @(posedge clk);
		chk_gain();
		setr(OFS_LINE1_MIX, {r13[7:2], AIM_STEP_SECOND});
		tgt = 7'(gm - 4);
		tk(6);
		tgt = 7'($random(seed));
		setr(OFS_LINE1_MIX, {r13[7:2], AIM_STEP_OFF_B});
		tk(1);
		$display("test stepping done");
		// second reset must bring every field and the gain back
		@(posedge clk) #1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		r12 = RST_MIC3_MIX;
		r13 = RST_LINE1_MIX;
		gm = 0;
		ph = 0;
		chk_mix();
		chk_gain();
		chk_rd(OFS_MIC3_MIX, RST_MIC3_MIX);
		chk_rd(OFS_LINE1_MIX, RST_LINE1_MIX);
		$display("test reset again done");
		end_of_test();
	end
endmodule
